/* File: src/ulmic_ctrl.sv */
// Purpose: line status, modem control/status and interrupt enable of a fifo uart
// Assumes: all inputs synchronous to clk_sys_i; receiver, transmitter and flow
//          control engines sit outside and report through plain ports
// Notes: read data is registered, one cycle after rd_i
//
// Notes on behaviour
// - line status bit 0 is one while the receive fifo holds a character.
// - line status bit 1 is set by a receive overrun, cleared by a line status read.
// - line status bits 4:2 show break, framing, parity flags of fifo head.
// - framing error is stored with its character, shown at fifo head.
// - break is flagged in bit 4 and its character stored as zero.
// - line status bit 5 is one while the transmit holding fifo is empty.
// - line status bit 6 is one when holding fifo and shifter are empty.
// - line status bit 7 is one while any flagged character is in fifo.
// - line status read keeps rx read pointer; holding register read advances.
// - outside loopback, modem control bits 0,1 drive dtr and rts low and auto rts overrides rts.
// - bit 2 enables fifo ready status outside loopback; bit 3 drives or floats interrupt.
// - bit 4 loops tx to rx and control bits 3:0 into status.
// - in loopback status bits 7:4 equal control bits 3,2,0,1.
// - bit 5 enables xon any; bit 6 opens trigger and control levels while enhanced write enable is set.
// - bit 7 selects input clock divide by one or by four.
// - modem control bits 7:5 change only with enhanced write enable.
// - status bits 0,1,3 set on cts, dsr, cd change; read clears.
// - status bit 2 set on ring rising edge; read clears.
// - outside loopback status bits 7:4 are inverted modem inputs.
// - enable bits gate each interrupt source; bit 4 enables sleep.
// - enable bits 7:4 change only with enhanced write enable.
// - re-enabling transmit interrupt while below threshold raises it again.
// - enhanced write enable protects enable and modem control fields.
`default_nettype none

module ulmic_ctrl
	import ulmic_pkg::*;
#(
	parameter int RX_DEPTH = RX_DEPTH_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic enh_wr_en_i,
	input wire logic rx_char_valid_i,
	input wire logic [7:0] rx_char_i,
	input wire logic rx_parity_err_i,
	input wire logic rx_frame_err_i,
	input wire logic rx_break_i,
	input wire logic tx_fifo_empty_i,
	input wire logic tx_shift_empty_i,
	input wire logic tx_below_thresh_i,
	input wire logic tx_serial_i,
	input wire logic sin_i,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic cd_n_i,
	input wire logic auto_rts_en_i,
	input wire logic auto_rts_n_i,
	input wire logic xoff_pend_i,
	input wire logic rts_pend_i,
	input wire logic cts_pend_i,
	output logic tx_pin_o,
	output logic rx_line_o,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic irq_o,
	output logic irq_oe_o,
	output logic sleep_en_o,
	output logic xon_any_o,
	output logic tcr_tlr_access_o,
	output logic fifo_rdy_en_o,
	output logic presc_tick_o
);

	localparam int PW = $clog2(RX_DEPTH);
	localparam int CW = $clog2(RX_DEPTH + 1);

	// ----------------------------------------
	// register access decode
	// ----------------------------------------
	logic wr_mcr;
	logic wr_ier;
	logic rd_rhr;
	logic rd_lsr;
	logic rd_msr;

	assign wr_mcr = wr_i && (addr_i == ADR_MCR);
	assign wr_ier = wr_i && (addr_i == ADR_IER);
	assign rd_rhr = rd_i && (addr_i == ADR_RHR);
	assign rd_lsr = rd_i && (addr_i == ADR_LSR);
	assign rd_msr = rd_i && (addr_i == ADR_MSR);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [7:0] modem_control;
	logic [7:0] interrupt_enable;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			modem_control <= MCR_RST;
		end else if (wr_mcr) begin
			modem_control[MCR_PROT_LO-1:0] <= wdata_i[MCR_PROT_LO-1:0];
			if (enh_wr_en_i) begin
				modem_control[7:MCR_PROT_LO] <= wdata_i[7:MCR_PROT_LO];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			interrupt_enable <= IER_RST;
		end else if (wr_ier) begin
			interrupt_enable[IER_PROT_LO-1:0] <= wdata_i[IER_PROT_LO-1:0];
			if (enh_wr_en_i) begin
				interrupt_enable[7:IER_PROT_LO] <= wdata_i[7:IER_PROT_LO];
			end
		end
	end

	// ----------------------------------------
	// receive fifo with per-character flags
	// ----------------------------------------
	// entry layout: {break, framing, parity, data}
	logic [10:0] rx_mem [RX_DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] rx_cnt;
	logic [CW-1:0] err_cnt;
	logic rx_ovr;
	logic rx_empty;
	logic rx_full;
	logic push;
	logic pop;
	logic [10:0] push_ent;
	logic [10:0] head;
	logic push_flag;
	logic head_flag;

	assign rx_empty = (rx_cnt == '0);
	assign rx_full = (rx_cnt == CW'(RX_DEPTH));
	assign push = rx_char_valid_i && !rx_full;
	assign pop = rd_rhr && !rx_empty;
	assign head = rx_empty ? 11'h000 : rx_mem[rd_ptr];
	assign push_flag = rx_break_i || rx_frame_err_i || rx_parity_err_i;
	assign head_flag = |head[10:8];

	// a break always stores a zero character whatever the shifter held
	always_comb begin
		push_ent = {rx_break_i, rx_frame_err_i, rx_parity_err_i, rx_char_i};
		if (rx_break_i) begin
			push_ent[7:0] = BRK_CHAR;
		end
	end

	generate
		for (genvar i = 0; i < RX_DEPTH; i++) begin : g_rx_ent
			always_ff @(posedge clk_sys_i) begin
				if (rst_i) begin
					rx_mem[i] <= 11'h000;
				end else if (push && (wr_ptr == PW'(i))) begin
					rx_mem[i] <= push_ent;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= PW'(wr_ptr + 1'b1);
		end
	end

	// only a holding register read moves the read side
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= PW'(rd_ptr + 1'b1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_cnt <= '0;
		end else if (push && !pop) begin
			rx_cnt <= CW'(rx_cnt + 1'b1);
		end else if (pop && !push) begin
			rx_cnt <= CW'(rx_cnt - 1'b1);
		end
	end

	// counting flagged entries keeps bit 7 exact without scanning the fifo
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			err_cnt <= '0;
		end else if ((push && push_flag) && !(pop && head_flag)) begin
			err_cnt <= CW'(err_cnt + 1'b1);
		end else if ((pop && head_flag) && !(push && push_flag)) begin
			err_cnt <= CW'(err_cnt - 1'b1);
		end
	end

	// overrun: set wins over the clear of a line status read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_ovr <= 1'b0;
		end else if (rx_char_valid_i && rx_full) begin
			rx_ovr <= 1'b1;
		end else if (rd_lsr) begin
			rx_ovr <= 1'b0;
		end
	end

	// ----------------------------------------
	// modem status
	// ----------------------------------------
	logic [3:0] lvl;
	logic [3:0] lvl_prev;
	logic [3:0] delta;
	logic [3:0] chg;

	// lvl order: cts, dsr, ri, cd, active high
	always_comb begin
		if (modem_control[MCR_LOOP]) begin
			lvl = {modem_control[MCR_INT], modem_control[MCR_RDY], modem_control[MCR_DTR], modem_control[MCR_RTS]};
		end else begin
			lvl = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
		end
	end

	always_comb begin
		chg = lvl ^ lvl_prev;
		chg[MSR_RI] = lvl[MSR_RI] && !lvl_prev[MSR_RI];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			lvl_prev <= 4'h0;
		end else begin
			lvl_prev <= lvl;
		end
	end

	// a change seen in the read cycle survives the clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			delta <= 4'h0;
		end else if (rd_msr) begin
			delta <= chg;
		end else begin
			delta <= delta | chg;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [7:0] line_status;
	logic [7:0] next_rdata;

	always_comb begin
		line_status = 8'h00;
		line_status[LSR_DATA] = !rx_empty;
		line_status[LSR_OVR] = rx_ovr;
		line_status[LSR_BRK:LSR_PE] = head[10:8];
		line_status[LSR_THRE] = tx_fifo_empty_i;
		line_status[LSR_TEMT] = tx_fifo_empty_i && tx_shift_empty_i;
		line_status[LSR_ERR] = (err_cnt != '0);
	end

	always_comb begin
		case (addr_i)
			ADR_RHR: next_rdata = head[7:0];
			ADR_IER: next_rdata = interrupt_enable;
			ADR_MCR: next_rdata = modem_control;
			ADR_LSR: next_rdata = line_status;
			ADR_MSR: next_rdata = {lvl, delta};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// transmit holding interrupt
	// ----------------------------------------
	logic thr_pend;
	logic below_prev;
	logic thr_reen;

	assign thr_reen = wr_ier && !interrupt_enable[IER_THR] && wdata_i[IER_THR];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			below_prev <= 1'b0;
		end else begin
			below_prev <= tx_below_thresh_i;
		end
	end

	// falling below threshold, or enabling again while below, re-arms the source;
	// a disabled source drops its request so that the re-enable is what raises it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			thr_pend <= 1'b0;
		end else if (!tx_below_thresh_i) begin
			thr_pend <= 1'b0;
		end else if (!below_prev || thr_reen) begin
			thr_pend <= 1'b1;
		end else if (!interrupt_enable[IER_THR]) begin
			thr_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt output
	// ----------------------------------------
	logic [7:0] src;
	logic irq_any;

	always_comb begin
		src = 8'h00;
		src[IER_RX] = !rx_empty;
		src[IER_THR] = thr_pend;
		src[IER_LS] = rx_ovr || head_flag;
		src[IER_MS] = |delta;
		src[IER_XOFF] = xoff_pend_i;
		src[IER_RTS] = rts_pend_i;
		src[IER_CTS] = cts_pend_i;
		irq_any = |(src & interrupt_enable);
	end

	// the pin floats unless bit 3 asks for it to be driven
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			irq_oe_o <= 1'b0;
		end else begin
			irq_o <= irq_any && modem_control[MCR_INT];
			irq_oe_o <= modem_control[MCR_INT];
		end
	end

	// ----------------------------------------
	// modem pins and loopback
	// ----------------------------------------
	// in loopback the pins idle inactive and tx idles at mark
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			dtr_n_o <= 1'b1;
			rts_n_o <= 1'b1;
			tx_pin_o <= 1'b1;
			rx_line_o <= 1'b1;
		end else begin
			dtr_n_o <= modem_control[MCR_LOOP] || !modem_control[MCR_DTR];
			if (modem_control[MCR_LOOP]) begin
				rts_n_o <= 1'b1;
			end else if (auto_rts_en_i) begin
				rts_n_o <= auto_rts_n_i;
			end else begin
				rts_n_o <= !modem_control[MCR_RTS];
			end
			tx_pin_o <= modem_control[MCR_LOOP] ? 1'b1 : tx_serial_i;
			rx_line_o <= modem_control[MCR_LOOP] ? tx_serial_i : sin_i;
		end
	end

	// ----------------------------------------
	// feature enables
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sleep_en_o <= 1'b0;
			xon_any_o <= 1'b0;
			tcr_tlr_access_o <= 1'b0;
			fifo_rdy_en_o <= 1'b0;
		end else begin
			sleep_en_o <= interrupt_enable[IER_SLEEP];
			xon_any_o <= modem_control[MCR_XANY];
			tcr_tlr_access_o <= modem_control[MCR_TACC] && enh_wr_en_i;
			fifo_rdy_en_o <= modem_control[MCR_RDY] && !modem_control[MCR_LOOP];
		end
	end

	// ----------------------------------------
	// input clock prescaler
	// ----------------------------------------
	logic [1:0] presc_cnt;

	// free running so a mode switch costs at most three cycles of phase
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			presc_cnt <= 2'h0;
			presc_tick_o <= 1'b0;
		end else begin
			presc_cnt <= 2'(presc_cnt + 1'b1);
			presc_tick_o <= !modem_control[MCR_PRESC] || (presc_cnt == PRESC_LAST);
		end
	end

endmodule

`default_nettype wire

/* File: src/ulmic_pkg.sv */
// Purpose: shared constants of the uart line, modem and interrupt-enable block
// Assumes: 3-bit register address, 8-bit host data bus
// Notes: bit positions are indices into 8-bit registers
`default_nettype none

package ulmic_pkg;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [2:0] ADR_RHR = 3'h0;
	localparam logic [2:0] ADR_IER = 3'h1;
	localparam logic [2:0] ADR_MCR = 3'h4;
	localparam logic [2:0] ADR_LSR = 3'h5;
	localparam logic [2:0] ADR_MSR = 3'h6;

	// ----------------------------------------
	// line_status fields
	// ----------------------------------------
	localparam int LSR_DATA = 0;
	localparam int LSR_OVR = 1;
	localparam int LSR_PE = 2;
	localparam int LSR_FE = 3;
	localparam int LSR_BRK = 4;
	localparam int LSR_THRE = 5;
	localparam int LSR_TEMT = 6;
	localparam int LSR_ERR = 7;

	// ----------------------------------------
	// modem_control fields
	// ----------------------------------------
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_RDY = 2;
	localparam int MCR_INT = 3;
	localparam int MCR_LOOP = 4;
	localparam int MCR_XANY = 5;
	localparam int MCR_TACC = 6;
	localparam int MCR_PRESC = 7;
	localparam int MCR_PROT_LO = 5;

	// ----------------------------------------
	// interrupt_enable fields
	// ----------------------------------------
	localparam int IER_RX = 0;
	localparam int IER_THR = 1;
	localparam int IER_LS = 2;
	localparam int IER_MS = 3;
	localparam int IER_SLEEP = 4;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int IER_PROT_LO = 4;

	// ----------------------------------------
	// modem_status fields (delta bits 3:0, levels 7:4)
	// ----------------------------------------
	localparam int MSR_CTS = 0;
	localparam int MSR_DSR = 1;
	localparam int MSR_RI = 2;
	localparam int MSR_CD = 3;
	localparam int MSR_LVL = 4;

	// ----------------------------------------
	// reset values, sizes, counts
	// ----------------------------------------
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] BRK_CHAR = 8'h00;
	localparam int RX_DEPTH_DEF = 128;
	localparam logic [1:0] PRESC_LAST = 2'h3;

endpackage

`default_nettype wire

/* File: test/ulmic_modem.sv */
// Purpose: modem partner that answers the handshake lines
// Assumes: handshake lines active low, ring_i and carrier_i active high, driven from one clock
// Notes: slow_i delays the cts answer by four cycles
`default_nettype none
module ulmic_modem (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic dtr_n_i,
	input wire logic rts_n_i,
	input wire logic ring_i,
	input wire logic carrier_i,
	output logic cts_n_o,
	output logic dsr_n_o,
	output logic ri_n_o,
	output logic cd_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] rts_d = 4'hF;
	// cts trails rts like a real data set would
	always_ff @(posedge clk_i) begin
		rts_d <= {rts_d[2:0], rts_n_i};
	end
	assign cts_n_o = slow_i ? rts_d[3] : rts_d[0];
	assign dsr_n_o = dtr_n_i;
	assign ri_n_o = !ring_i;
	assign cd_n_o = !carrier_i;
endmodule
`default_nettype wire

/* File: test/ulmic_ctrl_chk.sv */
// Purpose: port assertions of ulmic_ctrl
// Assumes: host strobes are one-cycle pulses
// Notes: loopback state is only seen through mcr writes
`default_nettype none
module ulmic_ctrl_chk
	import ulmic_pkg::*;
#(
	parameter int RX_DEPTH = RX_DEPTH_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic enh_wr_en_i,
	input wire logic rx_char_valid_i,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic cd_n_i,
	input wire logic auto_rts_en_i,
	input wire logic auto_rts_n_i,
	input wire logic dtr_n_o,
	input wire logic rts_n_o,
	input wire logic irq_o,
	input wire logic irq_oe_o,
	input wire logic sleep_en_o,
	input wire logic xon_any_o,
	input wire logic presc_tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	wire [3:0] mdm_n = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
	// --
	// assertions
	// --
	a_dtr_from_wr: assert property (
		wr_i && addr_i == ADR_MCR && !wdata_i[MCR_LOOP] ##1 !(wr_i && addr_i == ADR_MCR)
		|=> dtr_n_o == !$past(wdata_i[MCR_DTR], 2)) else $error("dtr level wrong");
	a_rts_auto_flow: assert property (
		auto_rts_en_i && $past(auto_rts_en_i) |-> rts_n_o == $past(auto_rts_n_i))
		else $error("rts not from flow control");
	a_irq_needs_oe: assert property (irq_o |-> irq_oe_o) else $error("irq while floated");
	a_lsr_keeps_head: assert property (
		rd_i && addr_i == ADR_LSR && !rx_char_valid_i ##1 !rd_i && !rx_char_valid_i
		##1 rd_i && addr_i == ADR_LSR && !rx_char_valid_i
		|=> {rdata_o[4:2], rdata_o[0]} == {$past(rdata_o[4:2], 2), $past(rdata_o[0], 2)})
		else $error("status read moved the head");
	a_tick_gap_max: assert property (!presc_tick_o [*4] |-> 1'b0) else $error("tick gap too long");
	a_msr_read_clr: assert property (
		(!wr_i && $stable(mdm_n)) [*4] ##0 (rd_i && addr_i == ADR_MSR) ##1 (!wr_i && $stable(mdm_n))
		##1 (rd_i && addr_i == ADR_MSR && !wr_i && $stable(mdm_n)) |=> rdata_o[3:0] == 4'h0)
		else $error("delta bits survive read");
	a_irq_oe_wr: assert property (
		wr_i && addr_i == ADR_MCR && !wdata_i[MCR_LOOP] ##1 !(wr_i && addr_i == ADR_MCR)
		|=> irq_oe_o == $past(wdata_i[MCR_INT], 2)) else $error("irq enable wrong");
	a_ier_prot_hold: assert property (
		wr_i && addr_i == ADR_IER && !enh_wr_en_i ##1 !(wr_i && addr_i == ADR_IER) |=> $stable(sleep_en_o))
		else $error("sleep changed unprotected");
	a_mcr_prot_hold: assert property (
		wr_i && addr_i == ADR_MCR && !enh_wr_en_i ##1 !(wr_i && addr_i == ADR_MCR) |=> $stable(xon_any_o))
		else $error("xon any changed unprotected");
	c_irq: cover property (irq_o);
	c_div4: cover property ($fell(presc_tick_o));
	c_msr_rd: cover property (rd_i && addr_i == ADR_MSR);
endmodule
bind ulmic_ctrl ulmic_ctrl_chk #(.RX_DEPTH(RX_DEPTH)) u_chk (.clk_sys_i, .rst_i, .addr_i, .wr_i, .rd_i,
	.wdata_i, .rdata_o, .enh_wr_en_i, .rx_char_valid_i, .cts_n_i, .dsr_n_i, .ri_n_i, .cd_n_i, .auto_rts_en_i,
	.auto_rts_n_i, .dtr_n_o, .rts_n_o, .irq_o, .irq_oe_o, .sleep_en_o, .xon_any_o, .presc_tick_o);
`default_nettype wire

/* File: test/ulmic_ctrl_tb.sv */
// Purpose: self-checking bench of ulmic_ctrl
// Assumes: inputs change on the falling edge
// Notes: rx depth of 4 keeps the overrun case short
`default_nettype none
module ulmic_ctrl_tb import ulmic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 4;
	logic clk_sys_i, rst_i, wr_i, rd_i, enh_wr_en_i, rx_char_valid_i, rx_parity_err_i, rx_frame_err_i;
	logic rx_break_i, tx_fifo_empty_i, tx_shift_empty_i, tx_below_thresh_i, tx_serial_i, sin_i;
	logic auto_rts_en_i, auto_rts_n_i, xoff_pend_i, rts_pend_i, cts_pend_i, slow, ring, carrier;
	logic cts_n_i, dsr_n_i, ri_n_i, cd_n_i, tx_pin_o, rx_line_o, dtr_n_o, rts_n_o, irq_o, irq_oe_o;
	logic sleep_en_o, xon_any_o, tcr_tlr_access_o, fifo_rdy_en_o, presc_tick_o;
	logic [2:0] addr_i;
	logic [7:0] wdata_i, rx_char_i, rdata_o;
	int error_cnt = 0;
	int n_checks = 0;
	ulmic_ctrl #(.RX_DEPTH(DEPTH)) uut (.clk_sys_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
		.enh_wr_en_i, .rx_char_valid_i, .rx_char_i, .rx_parity_err_i, .rx_frame_err_i, .rx_break_i,
		.tx_fifo_empty_i, .tx_shift_empty_i, .tx_below_thresh_i, .tx_serial_i, .sin_i, .cts_n_i, .dsr_n_i,
		.ri_n_i, .cd_n_i, .auto_rts_en_i, .auto_rts_n_i, .xoff_pend_i, .rts_pend_i, .cts_pend_i, .tx_pin_o,
		.rx_line_o, .dtr_n_o, .rts_n_o, .irq_o, .irq_oe_o, .sleep_en_o, .xon_any_o, .tcr_tlr_access_o,
		.fifo_rdy_en_o, .presc_tick_o);
	ulmic_modem partner (.clk_i(clk_sys_i), .slow_i(slow), .dtr_n_i(dtr_n_o), .rts_n_i(rts_n_o),
		.ring_i(ring), .carrier_i(carrier), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i),
		.cd_n_o(cd_n_i));
	// --
	// bus and check tasks
	// --
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		wr_i = 1;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_sys_i);
		wr_i = 0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(negedge clk_sys_i);
		rd_i = 1;
		addr_i = a;
		@(negedge clk_sys_i);
		rd_i = 0;
		chk($sformatf("reg %0h", a), e, rdata_o);
	endtask
	task automatic push(input logic [7:0] d, input logic [2:0] f);
		@(negedge clk_sys_i);
		rx_char_valid_i = 1;
		rx_char_i = d;
		{rx_break_i, rx_frame_err_i, rx_parity_err_i} = f;
		@(negedge clk_sys_i);
		rx_char_valid_i = 0;
	endtask
	// bounded wait, a hang counts as a mismatch
	task automatic wirq(input logic e);
		int k;
		for (k = 0; k < 8 && irq_o !== e; k++)
			cyc(1);
		chk("irq", {7'h0, e}, {7'h0, irq_o});
		if (irq_o !== e) begin
			end_sim();
		end
	endtask
	task automatic tk(input int e);
		int k;
		k = 0;
		repeat (8) begin
			cyc(1);
			k += int'(presc_tick_o);
		end
		chk("ticks", 8'(e), 8'(k));
	endtask
	// --
	// scenarios
	// --
	task automatic t_rx();
		push(8'h55, 3'h2);
		push(8'h5A, 3'h4);
		push(8'hAA, 3'h0);
		rdc(ADR_LSR, 8'hE9);
		rdc(ADR_LSR, 8'hE9);
		rdc(ADR_RHR, 8'h55);
		rdc(ADR_LSR, 8'hF1);
		rdc(ADR_RHR, 8'h00);
		rdc(ADR_LSR, 8'h61);
		rdc(ADR_RHR, 8'hAA);
		rdc(ADR_LSR, 8'h60);
	endtask
	task automatic t_ovr();
		for (int i = 0; i <= DEPTH; i++) push(8'(i), 3'h0);
		rdc(ADR_LSR, 8'h63);
		rdc(ADR_LSR, 8'h61);
		for (int i = 0; i < DEPTH; i++) rdc(ADR_RHR, 8'(i));
		rdc(ADR_LSR, 8'h60);
		tx_fifo_empty_i = 0;
		rdc(ADR_LSR, 8'h00);
		tx_fifo_empty_i = 1;
		tx_shift_empty_i = 0;
		rdc(ADR_LSR, 8'h20);
		tx_shift_empty_i = 1;
	endtask
	task automatic t_mcr();
		wr(ADR_MCR, 8'hE7);
		rdc(ADR_MCR, 8'h07);
		chk("mcr pins", 8'h02, {4'h0, dtr_n_o, rts_n_o, fifo_rdy_en_o, xon_any_o});
		enh_wr_en_i = 1;
		wr(ADR_MCR, 8'hE8);
		rdc(ADR_MCR, 8'hE8);
		chk("mcr outs", 8'h1F, {2'h0, irq_o, dtr_n_o, rts_n_o, irq_oe_o, xon_any_o, tcr_tlr_access_o});
		tk(8 / 4);
		wr(ADR_MCR, 8'h00);
		tk(8);
		auto_rts_en_i = 1;
		auto_rts_n_i = 0;
		cyc(3);
		chk("auto rts", 8'h00, {7'h0, rts_n_o});
		auto_rts_en_i = 0;
		auto_rts_n_i = 1;
		enh_wr_en_i = 0;
		wr(ADR_IER, 8'hFF);
		rdc(ADR_IER, 8'h0F);
		enh_wr_en_i = 1;
		wr(ADR_IER, 8'h10);
		rdc(ADR_IER, 8'h10);
		chk("sleep", 8'h01, {7'h0, sleep_en_o});
		wr(ADR_IER, 8'h00);
	endtask
	task automatic t_loop();
		rdc(ADR_MSR, 8'h03);
		wr(ADR_MCR, 8'h15);
		cyc(6);
		rdc(ADR_MSR, 8'h66);
		chk("loop pins", 8'h05, {4'h0, fifo_rdy_en_o, tx_pin_o, rx_line_o, dtr_n_o});
		wr(ADR_MCR, 8'h11);
		cyc(6);
		rdc(ADR_MSR, 8'h20);
		wr(ADR_MCR, 8'h1C);
		cyc(6);
		rdc(ADR_MSR, 8'hCE);
		wr(ADR_MCR, 8'h00);
		cyc(3);
		chk("pins", 8'h01, {6'h0, tx_pin_o, rx_line_o});
		rdc(ADR_MSR, 8'h08);
		wr(ADR_MCR, 8'h01);
		cyc(6);
		rdc(ADR_MSR, 8'h22);
		rdc(ADR_MSR, 8'h20);
		carrier = 1;
		slow = 1;
		wr(ADR_MCR, 8'h03);
		cyc(10);
		rdc(ADR_MSR, 8'hB9);
	endtask
	task automatic t_irq();
		wr(ADR_MCR, 8'h08);
		wr(ADR_IER, 8'h01);
		push(8'h11, 3'h0);
		wirq(1);
		rdc(ADR_RHR, 8'h11);
		wirq(0);
		wr(ADR_IER, 8'h04);
		push(8'h22, 3'h1);
		wirq(1);
		rdc(ADR_RHR, 8'h22);
		wirq(0);
		tx_below_thresh_i = 1;
		wr(ADR_IER, 8'h02);
		wirq(1);
		wr(ADR_IER, 8'h00);
		wirq(0);
		wr(ADR_IER, 8'h02);
		wirq(1);
		tx_below_thresh_i = 0;
		wirq(0);
		for (int i = 5; i < 8; i++) begin
			wr(ADR_IER, 8'(1 << i));
			{cts_pend_i, rts_pend_i, xoff_pend_i} = 3'h7;
			wirq(1);
			{cts_pend_i, rts_pend_i, xoff_pend_i} = ~3'(1 << (i - 5));
			wirq(0);
		end
		wr(ADR_MCR, 8'h00);
		cyc(1);
		chk("irq oe", 8'h00, {7'h0, irq_oe_o});
		wirq(0);
	endtask
	initial begin
		clk_sys_i = 0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		{rst_i, tx_fifo_empty_i, tx_shift_empty_i, auto_rts_n_i} = 4'hF;
		{wr_i, rd_i, enh_wr_en_i, rx_char_valid_i, rx_parity_err_i, rx_frame_err_i, rx_break_i} = 7'h00;
		{tx_below_thresh_i, tx_serial_i, sin_i, auto_rts_en_i, xoff_pend_i, rts_pend_i, cts_pend_i} = 7'h10;
		{slow, ring, carrier, addr_i, wdata_i, rx_char_i} = 22'h0;
		cyc(2);
		rst_i = 0;
		rdc(ADR_MCR, 8'h00);
		rdc(ADR_LSR, 8'h60);
		chk("rst pins", 8'h03, {6'h0, dtr_n_o, rts_n_o});
		t_rx();
		t_ovr();
		t_mcr();
		t_loop();
		t_irq();
		end_sim();
	end
endmodule
`default_nettype wire
